// File: hw/pin_cfg_pkg.sv
/*
 Shared constants for the general-purpose pin configuration block:
 register address, field positions, reset values and debounce timing.
 Assumes a 40 MHz system clock and an internal register port fed by
 the serial bus engine.
*/
package pin_cfg_pkg;
    // register address and field positions
    localparam logic [7:0] CFG_ADDR = 8'h11;
    localparam int RSVD_BIT = 7;
    localparam int UNUSED_BIT = 6;
    localparam int ALT_BIT = 5;
    localparam int DBEN_BIT = 4;
    localparam int DOUT_BIT = 3;
    localparam int DRIVER_TYPE_BIT = 2;
    localparam int LEVEL_BIT = 1;
    localparam int DIR_BIT = 0;

    // reset values and field encodings
    localparam logic RSVD_RST = 1'h0;
    localparam logic DBEN_RST = 1'h0;
    localparam logic DOUT_RST = 1'h0;
    localparam logic DRIVER_TYPE_RST = 1'h0;
    localparam logic DIR_RST = 1'h1;
    localparam logic DIR_INPUT = 1'h1;
    localparam logic DRIVER_PUSH_PULL = 1'h1;

    // debounce timing
    localparam longint CLK_HZ = 64'd40000000;
    localparam longint DEBOUNCE_MS = 64'd30;
    localparam longint DEBOUNCE_CYC_L = (DEBOUNCE_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] DEBOUNCE_CYCLES = DEBOUNCE_CYC_L[CNT_W-1:0];
endpackage

// File: hw/level_filter_if.sv
/*
 Interface joining the pin block to its debounce filter.
 Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
interface level_filter_if;
    logic sync_level;
    logic filter_enable;
    logic filtered_level;

    modport owner
    (
        output sync_level,
        output filter_enable,
        input filtered_level
    );
    modport filter
    (
        input sync_level,
        input filter_enable,
        output filtered_level
    );
endinterface

// File: hw/level_filter.sv
/*
 Debounce filter for the synchronised pin level.
 Assumes its input is already synchronous to mclk.
*/
`timescale 1ns/1ps
module level_filter
#(
    parameter logic [pin_cfg_pkg::CNT_W-1:0] DEBOUNCE_CYCLES = pin_cfg_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_sync_b,
    // filter side
    level_filter_if.filter lf
);
    typedef struct packed
    {
        logic level;
        logic [pin_cfg_pkg::CNT_W-1:0] count;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;

    // pass-through when off; otherwise a change must hold a full interval
    always_comb
    begin
        st_next = st_reg;
        if (!lf.filter_enable)
        begin
            st_next.level = lf.sync_level;
            st_next.count = '0;
        end
        else if (lf.sync_level == st_reg.level)
        begin
            st_next.count = '0; // bounce back restarts the interval
        end
        else if (st_reg.count >= DEBOUNCE_CYCLES - 1'b1)
        begin
            st_next.level = lf.sync_level;
            st_next.count = '0;
        end
        else
        begin
            st_next.count = st_reg.count + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign lf.filtered_level = st_reg.level;
endmodule // level_filter

// File: hw/gpio_pin_config_port.sv
/*
 Configuration register and pin logic for general pin zero.
 Assumes the serial bus engine presents single-cycle read and write
 strobes with an 8-bit register address, and that the pad resolves
 pin_out/pin_oe into the wire level.
 The sync flops reset low, so after reset the level bit needs a few
 cycles before it shows a pin that idles high.
*/
`timescale 1ns/1ps
module gpio_pin_config_port
#(
    parameter logic ALT_RST = 1'h0, // factory-programmed default
    parameter logic [pin_cfg_pkg::CNT_W-1:0] DEBOUNCE_CYCLES = pin_cfg_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port from the serial bus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // power sequencer enable for buck_boost_channel_two
    input wire logic seq_enable,
    // general_pin_zero pad
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe
);
    // block state apart from reset sync and filter: config bits, sync chain, read data, pad drive
    typedef struct packed
    {
        logic rsvd;
        logic alt;
        logic dben;
        logic dout;
        logic driver_type;
        logic dir;
        logic sync1;
        logic sync2;
        logic [7:0] rdata;
        logic pin_out;
        logic pin_oe;
    } pin_state_t;

    pin_state_t st_reg;
    pin_state_t st_next;
    logic rst_meta_b;
    logic rst_sync_b;
    logic sampled_pin_level;
    logic [7:0] cfg_view;
    // address decode and pad role
    logic cfg_hit;
    logic wr_hit;
    logic rd_hit;

    // one-hot pad role keeps each drive case a single-bit test
    typedef enum logic [4:0]
    {
        PAD_ALTERNATE = 5'h01,
        PAD_INPUT = 5'h02,
        PAD_DRIVE_LOW = 5'h04,
        PAD_PUSH_HIGH = 5'h08,
        PAD_RELEASED = 5'h10
    } pad_role_t;
    pad_role_t pad_role;

    level_filter_if lf();

    level_filter
    #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
    )
    u_filter
    (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .lf(lf)
    );

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // filter hookup: only the second sync stage leaves this block
    assign lf.sync_level = st_reg.sync2;
    assign lf.filter_enable = st_reg.dben;
    assign sampled_pin_level = lf.filtered_level;

    // register image as software sees it; unused bit reads zero
    always_comb
    begin
        cfg_view = '0;
        cfg_view[pin_cfg_pkg::RSVD_BIT] = st_reg.rsvd;
        cfg_view[pin_cfg_pkg::UNUSED_BIT] = 1'b0;
        cfg_view[pin_cfg_pkg::ALT_BIT] = st_reg.alt;
        cfg_view[pin_cfg_pkg::DBEN_BIT] = st_reg.dben;
        cfg_view[pin_cfg_pkg::DOUT_BIT] = st_reg.dout;
        cfg_view[pin_cfg_pkg::DRIVER_TYPE_BIT] = st_reg.driver_type;
        cfg_view[pin_cfg_pkg::LEVEL_BIT] = sampled_pin_level;
        cfg_view[pin_cfg_pkg::DIR_BIT] = st_reg.dir;
    end

    // one address decode shared by the write and read paths
    assign cfg_hit = (reg_addr == pin_cfg_pkg::CFG_ADDR);
    assign wr_hit = reg_wr && cfg_hit;
    assign rd_hit = reg_rd && cfg_hit;

    // pad role from the stored config; the alternate function overrides all
    always_comb
    begin
        if (st_reg.alt)
        begin
            pad_role = PAD_ALTERNATE;
        end
        else if (st_reg.dir == pin_cfg_pkg::DIR_INPUT)
        begin
            pad_role = PAD_INPUT;
        end
        else if (!st_reg.dout)
        begin
            pad_role = PAD_DRIVE_LOW;
        end
        else if (st_reg.driver_type == pin_cfg_pkg::DRIVER_PUSH_PULL)
        begin
            pad_role = PAD_PUSH_HIGH;
        end
        else
        begin
            pad_role = PAD_RELEASED;
        end
    end

    // next state: sync chain, register access, pad drive
    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;

        // write: level bit is read-only, bit 6 has no storage
        if (wr_hit)
        begin
            st_next.rsvd = reg_wdata[pin_cfg_pkg::RSVD_BIT];
            st_next.alt = reg_wdata[pin_cfg_pkg::ALT_BIT];
            st_next.dben = reg_wdata[pin_cfg_pkg::DBEN_BIT];
            st_next.dout = reg_wdata[pin_cfg_pkg::DOUT_BIT];
            st_next.driver_type = reg_wdata[pin_cfg_pkg::DRIVER_TYPE_BIT];
            st_next.dir = reg_wdata[pin_cfg_pkg::DIR_BIT];
        end

        // read: unmapped addresses answer zero; a read beside a write sees the old value
        if (reg_rd)
        begin
            st_next.rdata = rd_hit ? cfg_view : 8'h00;
        end

        // pad drive from the stored config, so it lags the write by one edge
        unique case (pad_role)
            PAD_ALTERNATE:
            begin
                st_next.pin_oe = 1'b1;
                st_next.pin_out = seq_enable;
            end
            PAD_INPUT:
            begin
                st_next.pin_oe = 1'b0;
                st_next.pin_out = 1'b0; // value and driver type ignored here
            end
            PAD_DRIVE_LOW:
            begin
                st_next.pin_oe = 1'b1;
                st_next.pin_out = 1'b0;
            end
            PAD_PUSH_HIGH:
            begin
                st_next.pin_oe = 1'b1;
                st_next.pin_out = 1'b1;
            end
            PAD_RELEASED:
            begin
                st_next.pin_oe = 1'b0;
                st_next.pin_out = 1'b0; // open drain never drives high
            end
        endcase
    end

    // single state register; pin starts released as an input
    always_ff @(posedge mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            st_reg <= '0;
            st_reg.rsvd <= pin_cfg_pkg::RSVD_RST;
            st_reg.alt <= ALT_RST;
            st_reg.dben <= pin_cfg_pkg::DBEN_RST;
            st_reg.dout <= pin_cfg_pkg::DOUT_RST;
            st_reg.driver_type <= pin_cfg_pkg::DRIVER_TYPE_RST;
            st_reg.dir <= pin_cfg_pkg::DIR_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // every output comes straight from a state flop
    assign reg_rdata = st_reg.rdata;
    assign pin_out = st_reg.pin_out;
    assign pin_oe = st_reg.pin_oe;
endmodule // gpio_pin_config_port

// File: verification/gpio_pin_monitor.sv
/*
 Checker for the pin configuration block, top-level ports only.
 Assumes one clock and the default reset value of the alternate bit.
*/
`timescale 1ns/1ps
module gpio_pin_monitor
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // pin side
    input wire logic seq_enable,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe
);
    logic [7:0] cfg_reg;
    logic [7:0] prev_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // shadow of the register; prev_reg is what the pin logic sees
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_reg <= 8'h01;
            prev_reg <= 8'h01;
        end
        else
        begin
            prev_reg <= cfg_reg;
            if (reg_wr && reg_addr == pin_cfg_pkg::CFG_ADDR)
            begin
                cfg_reg <= reg_wdata;
            end
        end
    end
    a_input_no_drive: assert property (prev_reg[0] && !prev_reg[5] |-> !pin_oe)
        else $error("pin driven while input");
    a_output_low: assert property (prev_reg[5:3] == 3'h0 && !prev_reg[0] |-> pin_oe && !pin_out)
        else $error("output low not driven");
    a_push_high: assert property (prev_reg[5:2] == 4'h3 && !prev_reg[0] |-> pin_oe && pin_out)
        else $error("push-pull high not driven");
    a_open_release: assert property (prev_reg[5:2] == 4'h2 && !prev_reg[0] |-> !pin_oe)
        else $error("open-drain high not released");
    a_alt_follow: assert property (prev_reg[5] |-> pin_oe && pin_out == $past(seq_enable))
        else $error("alternate output wrong");
    a_read_format: assert property (reg_rd && reg_addr == 8'h11 |=>
        {reg_rdata[7:2], reg_rdata[0]} == {$past(cfg_reg[7]), 1'b0, $past(cfg_reg[5:2]), $past(cfg_reg[0])})
        else $error("read fields wrong");
    a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h11 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_level_follow: assert property ($stable(pin_in)[*4] ##0 (reg_rd && reg_addr == 8'h11 && !cfg_reg[4])
        |=> reg_rdata[1] == $past(pin_in))
        else $error("level bit wrong");
    cover property (reg_wr && reg_addr == 8'h11 && reg_wdata[5]);
    cover property (pin_oe && pin_out);
    cover property (reg_rd && reg_addr != 8'h11);
    cover property (reg_rd && reg_addr == 8'h11 && cfg_reg[4]);
endmodule // gpio_pin_monitor

// File: verification/pin_partner.sv
/*
 Far side of general pin zero: pull-up plus an outside driver.
 Assumes the bench enables the outside driver only for configs that leave the pad undriven (input or released).
*/
`timescale 1ns/1ps
module pin_partner
(
    // pad from the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // outside driver
    input wire logic ext_en,
    input wire logic ext_val,
    // wire level
    output logic pin_in
);
    // pull-up wins when nobody drives, so a released pad reads high
    assign pin_in = pin_oe ? pin_out : (ext_en ? ext_val : 1'b1);
endmodule // pin_partner

// File: verification/testbench.sv
/*
 Self-checking bench for the pin block with corner and random configs.
 Assumes the debounce count is shortened to 16 cycles.
*/
`timescale 1ns/1ps
module testbench;
    localparam logic [pin_cfg_pkg::CNT_W-1:0] DEB = 16;
    logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, seq_enable = 0, ext_en = 0, ext_val = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got;
    logic pin_in, pin_out, pin_oe;
    logic [7:0] corner [5] = '{8'h01, 8'h00, 8'h0c, 8'h08, 8'h23};
    int err_count = 0, tests_run = 0, seed = 32'he4fe;
    gpio_pin_config_port #(.DEBOUNCE_CYCLES(DEB)) uut (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .seq_enable(seq_enable), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    pin_partner far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
    initial forever #12.5 mclk = ~mclk;
    task automatic check(string name, logic [7:0] exp, logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", name, exp, seen);
        end
    endtask
    task automatic check_pad(logic [1:0] exp, logic [1:0] seen);
        check("pad", {6'h0, exp}, {6'h0, seen});
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        #2 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge mclk);
        #2 reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        #2 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge mclk);
        #2 reg_rd = 0;
        got = reg_rdata;
    endtask
    // expected {oe, out} for a config and sequencer level
    function automatic logic [1:0] drive(logic [7:0] c, logic s);
        if (c[5])
            return {1'b1, s};
        if (c[0])
            return 2'b00;
        return c[3] ? {c[2], c[2]} : 2'b10;
    endfunction
    // apply one config, then check pad and read-back
    task automatic trial(logic [7:0] c);
        logic [1:0] d;
        logic lv;
        seq_enable = 1'($random(seed));
        d = drive(c, seq_enable);
        ext_en = !d[1] && 1'($random(seed));
        ext_val = 1'($random(seed));
        lv = d[1] ? d[0] : (ext_en ? ext_val : 1'b1);
        wr(8'h11, c);
        repeat (4) @(posedge mclk);
        #2;
        check_pad(d, {pin_oe, pin_out});
        rd(8'h11);
        check("cfg", {2'h0, c[5:2], lv, c[0]}, got);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard, well past the expected run
    initial
    begin
        #150000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        #2 rst_b = 1;
        repeat (6) @(posedge mclk); // reset sync, pin sync and filter fill first
        rd(8'h11);
        check("reset", 8'h03, got);
        foreach (corner[i])
            trial(corner[i]);
        // debounce stays off here; bit 1 written at random to show it is read-only
        repeat (40)
            trial(8'($random(seed)) & 8'h2f);
        rd(8'h10);
        check("unmapped", 8'h00, got);
        {ext_en, ext_val} = 2'b11;
        wr(8'h11, 8'h11);
        repeat (DEB + 8) @(posedge mclk);
        #2 ext_val = 0;
        repeat (DEB - 4) @(posedge mclk);
        #2 ext_val = 1;
        rd(8'h11);
        check("glitch", 8'h13, got);
        ext_val = 0;
        repeat (DEB + 8) @(posedge mclk);
        rd(8'h11);
        check("settled", 8'h11, got);
        wrap_up();
    end
endmodule // testbench
bind gpio_pin_config_port gpio_pin_monitor mon (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .seq_enable(seq_enable), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
